// File: verilog/pwehc_pkg.sv
// Package: register map, field layout and types of the posted-write error and host control bank
package pwehc_pkg;

    // ==========================================================
    // Register byte offsets
    localparam logic [7:0] PWEHC_OFS_FAIL_LOW = 8'h38;
    localparam logic [7:0] PWEHC_OFS_FAIL_HIGH = 8'h3c;
    localparam logic [7:0] PWEHC_OFS_ORG_ID = 8'h40;
    localparam logic [7:0] PWEHC_OFS_FLAGS_SET = 8'h50;
    localparam logic [7:0] PWEHC_OFS_FLAGS_CLR = 8'h54;
    localparam logic [7:0] PWEHC_OFS_IRQ_STATUS = 8'h60;
    localparam logic [7:0] PWEHC_OFS_IRQ_CLEAR = 8'h64;
    localparam logic [7:0] PWEHC_OFS_IRQ_ENABLE = 8'h68;

    // ==========================================================
    // Field layout of the high capture register
    localparam int PWEHC_HI_OFS_LSB = 0;
    localparam int PWEHC_HI_OFS_MSB = 15;
    localparam int PWEHC_HI_NODE_LSB = 16;
    localparam int PWEHC_HI_NODE_MSB = 21;
    localparam int PWEHC_HI_BUS_LSB = 22;
    localparam int PWEHC_HI_BUS_MSB = 31;

    // ==========================================================
    // Host flag access masks
    localparam logic [31:0] PWEHC_FLAG_SET_MASK = 32'he04f_0000;
    localparam logic [31:0] PWEHC_FLAG_CLR_MASK = 32'h604f_0000;
    localparam logic [31:0] PWEHC_FLAG_UPD_MASK = 32'h8001_0000;
    localparam int PWEHC_FLAG_BIT_ENH = 23;
    localparam logic [31:0] PWEHC_FLAG_RESET = 32'h0080_0000;

    // Arbitrary neutral identity value
    localparam logic [31:0] PWEHC_ORG_ID_VALUE = 32'h0000_a5a5;

    // Interrupt bit positions
    localparam int PWEHC_IRQ_BIT_FAIL = 0;
    localparam logic [31:0] PWEHC_IRQ_MASK = 32'h0000_0001;

    // AXI responses
    localparam logic [1:0] PWEHC_RESP_OKAY = 2'b00;
    localparam logic [1:0] PWEHC_RESP_SLVERR = 2'b10;

    // ==========================================================
    // Carrier types
    typedef struct packed {
        logic [47:0] dest_offset;
        logic [9:0] bus_num;
        logic [5:0] node_num;
    } pwehc_fail_t;

    typedef struct packed {
        logic valid;
        logic [31:0] value;
    } pwehc_upd_t;

endpackage

// File: verilog/pwehc_regs.sv
// Posted-write error capture, organisation identifier and host control flag registers
//
// Added by the designer: the AXI4-Lite register port.
`timescale 1ns/1ps
`default_nettype none
// Behaviour
// - A failed posted write captures its error information into both capture registers.
// - Low capture register holds destination offset bits 31..0.
// - High capture register bits 15..0 hold destination offset bits 47..32.
// - High bits 31..22 bus number, 21..16 node number of requester.
// - Capture registers at 38h and 3Ch are read-only, hardware updated.
// - Identifier at 40h returns a fixed value; writes are ignored.
// - Host flags set at 50h, cleared at 54h.
// - Per-bit access: 31 RSU, 30,29,22,19,18,17 RSC, 16 RSCU, others RO.
// - Flag bit 23 resets to 1 unless loaded from configuration memory.
module pwehc_regs (
    input wire logic aclk, // Register clock
    input wire logic aresetn, // Synchronous reset, active low
    input wire logic [7:0] s_axi_awaddr, // Write address
    input wire logic s_axi_awvalid, // Write address valid
    output logic s_axi_awready, // Write address ready
    input wire logic [31:0] s_axi_wdata, // Write data
    input wire logic [3:0] s_axi_wstrb, // Write byte strobes
    input wire logic s_axi_wvalid, // Write data valid
    output logic s_axi_wready, // Write data ready
    output logic [1:0] s_axi_bresp, // Write response
    output logic s_axi_bvalid, // Write response valid
    input wire logic s_axi_bready, // Write response ready
    input wire logic [7:0] s_axi_araddr, // Read address
    input wire logic s_axi_arvalid, // Read address valid
    output logic s_axi_arready, // Read address ready
    output logic [31:0] s_axi_rdata, // Read data
    output logic [1:0] s_axi_rresp, // Read response
    output logic s_axi_rvalid, // Read data valid
    input wire logic s_axi_rready, // Read data ready
    input wire logic fail_valid, // Posted write failure pulse
    input wire pwehc_pkg::pwehc_fail_t fail_info, // Failed request details
    input wire pwehc_pkg::pwehc_upd_t flag_update, // Hardware update of U bits
    input wire logic cfg_load_valid, // Configuration memory load pulse
    input wire logic cfg_enh_value, // Loaded value of bit 23
    output logic [31:0] host_flags, // Current host flags
    output logic irq // Level interrupt
);
    import pwehc_pkg::*;

    // ==========================================================
    // State
    logic aw_got_ff, nxt_aw_got;
    logic w_got_ff, nxt_w_got;
    logic [7:0] awaddr_ff, nxt_awaddr;
    logic [31:0] wdata_ff, nxt_wdata;
    logic [3:0] wstrb_ff, nxt_wstrb;
    logic bvalid_ff, nxt_bvalid;
    logic [1:0] bresp_ff, nxt_bresp;
    logic rvalid_ff, nxt_rvalid;
    logic [1:0] rresp_ff, nxt_rresp;
    logic [31:0] rdata_ff, nxt_rdata;
    logic [31:0] cap_low_ff, nxt_cap_low;
    logic [31:0] cap_high_ff, nxt_cap_high;
    logic [31:0] flags_ff, nxt_flags;
    logic [31:0] irq_stat_ff, nxt_irq_stat;
    logic [31:0] irq_en_ff, nxt_irq_en;
    logic irq_ff, nxt_irq;
    logic awready_ff, nxt_awready;
    logic wready_ff, nxt_wready;
    logic arready_ff, nxt_arready;
    logic [31:0] wmask;
    logic wr_fire;
    logic wr_hit;
    logic [31:0] rd_val;
    logic rd_hit;

    always_comb begin
        for (int i = 0; i < 4; i++) begin
            wmask[i*8 +: 8] = {8{wstrb_ff[i]}};
        end
    end

    // ==========================================================
    // Write channel: address and data accepted in either order
    assign wr_fire = aw_got_ff && w_got_ff && !bvalid_ff;

    always_comb begin
        nxt_aw_got = aw_got_ff;
        nxt_w_got = w_got_ff;
        nxt_awaddr = awaddr_ff;
        nxt_wdata = wdata_ff;
        nxt_wstrb = wstrb_ff;
        nxt_bvalid = bvalid_ff;
        nxt_bresp = bresp_ff;
        wr_hit = 1'b0;
        unique case (awaddr_ff)
            PWEHC_OFS_FAIL_LOW, PWEHC_OFS_FAIL_HIGH, PWEHC_OFS_ORG_ID, PWEHC_OFS_FLAGS_SET,
            PWEHC_OFS_FLAGS_CLR, PWEHC_OFS_IRQ_STATUS, PWEHC_OFS_IRQ_CLEAR,
            PWEHC_OFS_IRQ_ENABLE: wr_hit = 1'b1;
            default: wr_hit = 1'b0;
        endcase
        if (s_axi_awvalid && s_axi_awready) begin
            nxt_aw_got = 1'b1;
            nxt_awaddr = s_axi_awaddr;
        end
        if (s_axi_wvalid && s_axi_wready) begin
            nxt_w_got = 1'b1;
            nxt_wdata = s_axi_wdata;
            nxt_wstrb = s_axi_wstrb;
        end
        if (wr_fire) begin
            nxt_aw_got = 1'b0;
            nxt_w_got = 1'b0;
            nxt_bvalid = 1'b1;
            nxt_bresp = wr_hit ? PWEHC_RESP_OKAY : PWEHC_RESP_SLVERR;
        end
        if (bvalid_ff && s_axi_bready) begin
            nxt_bvalid = 1'b0;
        end
        // Registered readies: no path from aresetn or valid straight to a port
        nxt_awready = !nxt_aw_got && !nxt_bvalid;
        nxt_wready = !nxt_w_got && !nxt_bvalid;
    end

    // ==========================================================
    // Capture registers
    always_comb begin
        nxt_cap_low = cap_low_ff;
        nxt_cap_high = cap_high_ff;
        if (fail_valid) begin
            nxt_cap_low = fail_info.dest_offset[31:0];
            nxt_cap_high[PWEHC_HI_OFS_MSB:PWEHC_HI_OFS_LSB] = fail_info.dest_offset[47:32];
            nxt_cap_high[PWEHC_HI_BUS_MSB:PWEHC_HI_BUS_LSB] = fail_info.bus_num;
            nxt_cap_high[PWEHC_HI_NODE_MSB:PWEHC_HI_NODE_LSB] = fail_info.node_num;
        end
    end

    // ==========================================================
    // Host flags and interrupt registers
    always_comb begin
        nxt_flags = flags_ff;
        nxt_irq_stat = irq_stat_ff;
        nxt_irq_en = irq_en_ff;
        // Software first, hardware after so its update wins a same-cycle race
        if (wr_fire) begin
            unique case (awaddr_ff)
                PWEHC_OFS_FLAGS_SET: nxt_flags = flags_ff | (wdata_ff & wmask & PWEHC_FLAG_SET_MASK);
                PWEHC_OFS_FLAGS_CLR: nxt_flags = flags_ff & ~(wdata_ff & wmask & PWEHC_FLAG_CLR_MASK);
                PWEHC_OFS_IRQ_CLEAR: nxt_irq_stat = irq_stat_ff & ~(wdata_ff & wmask);
                PWEHC_OFS_IRQ_ENABLE: nxt_irq_en = ((irq_en_ff & ~wmask) | (wdata_ff & wmask)) & PWEHC_IRQ_MASK;
                default: nxt_flags = flags_ff;
            endcase
        end
        if (flag_update.valid) begin
            nxt_flags = (nxt_flags & ~PWEHC_FLAG_UPD_MASK) | (flag_update.value & PWEHC_FLAG_UPD_MASK);
        end
        if (cfg_load_valid) begin
            nxt_flags[PWEHC_FLAG_BIT_ENH] = cfg_enh_value;
        end
        if (fail_valid) begin
            nxt_irq_stat[PWEHC_IRQ_BIT_FAIL] = 1'b1;
        end
        nxt_irq = |(nxt_irq_stat & nxt_irq_en);
    end

    // ==========================================================
    // Read channel
    always_comb begin
        rd_hit = 1'b1;
        unique case (s_axi_araddr)
            PWEHC_OFS_FAIL_LOW: rd_val = cap_low_ff;
            PWEHC_OFS_FAIL_HIGH: rd_val = cap_high_ff;
            PWEHC_OFS_ORG_ID: rd_val = PWEHC_ORG_ID_VALUE;
            PWEHC_OFS_FLAGS_SET: rd_val = flags_ff;
            PWEHC_OFS_FLAGS_CLR: rd_val = flags_ff;
            PWEHC_OFS_IRQ_STATUS: rd_val = irq_stat_ff;
            PWEHC_OFS_IRQ_ENABLE: rd_val = irq_en_ff;
            default: begin
                rd_val = 32'h0000_0000;
                rd_hit = 1'b0;
            end
        endcase
        nxt_rvalid = rvalid_ff;
        nxt_rdata = rdata_ff;
        nxt_rresp = rresp_ff;
        if (s_axi_arvalid && s_axi_arready) begin
            nxt_rvalid = 1'b1;
            nxt_rdata = rd_val;
            nxt_rresp = rd_hit ? PWEHC_RESP_OKAY : PWEHC_RESP_SLVERR;
        end else if (rvalid_ff && s_axi_rready) begin
            nxt_rvalid = 1'b0;
        end
        nxt_arready = !nxt_rvalid;
    end

    // ==========================================================
    // Registers
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            aw_got_ff <= 1'b0;
            w_got_ff <= 1'b0;
            awaddr_ff <= 8'h00;
            wdata_ff <= 32'h0000_0000;
            wstrb_ff <= 4'h0;
            bvalid_ff <= 1'b0;
            bresp_ff <= 2'h0;
            rvalid_ff <= 1'b0;
            rresp_ff <= 2'h0;
            rdata_ff <= 32'h0000_0000;
            // Capture contents are undefined after reset; zero keeps simulation clean
            cap_low_ff <= 32'h0000_0000;
            cap_high_ff <= 32'h0000_0000;
            flags_ff <= PWEHC_FLAG_RESET;
            irq_stat_ff <= 32'h0000_0000;
            irq_en_ff <= 32'h0000_0000;
            irq_ff <= 1'b0;
            awready_ff <= 1'b0;
            wready_ff <= 1'b0;
            arready_ff <= 1'b0;
        end else begin
            aw_got_ff <= nxt_aw_got;
            w_got_ff <= nxt_w_got;
            awaddr_ff <= nxt_awaddr;
            wdata_ff <= nxt_wdata;
            wstrb_ff <= nxt_wstrb;
            bvalid_ff <= nxt_bvalid;
            bresp_ff <= nxt_bresp;
            rvalid_ff <= nxt_rvalid;
            rresp_ff <= nxt_rresp;
            rdata_ff <= nxt_rdata;
            cap_low_ff <= nxt_cap_low;
            cap_high_ff <= nxt_cap_high;
            flags_ff <= nxt_flags;
            irq_stat_ff <= nxt_irq_stat;
            irq_en_ff <= nxt_irq_en;
            irq_ff <= nxt_irq;
            awready_ff <= nxt_awready;
            wready_ff <= nxt_wready;
            arready_ff <= nxt_arready;
        end
    end

    // Ready terms are flop outputs: one write and one read at a time
    assign s_axi_awready = awready_ff;
    assign s_axi_wready = wready_ff;
    assign s_axi_arready = arready_ff;
    assign s_axi_bvalid = bvalid_ff;
    assign s_axi_bresp = bresp_ff;
    assign s_axi_rvalid = rvalid_ff;
    assign s_axi_rdata = rdata_ff;
    assign s_axi_rresp = rresp_ff;
    assign host_flags = flags_ff;
    assign irq = irq_ff;

endmodule
`default_nettype wire

// File: test/pwehc_regs_props.sv
// Checker: port-level properties of the posted-write error and host control bank
`timescale 1ns/1ps
`default_nettype none
module pwehc_regs_props
import pwehc_pkg::*;
(
    input wire logic aclk, // Clock
    input wire logic aresetn, // Reset, active low
    input wire logic s_axi_awvalid, // Write address valid
    input wire logic s_axi_awready, // Write address ready
    input wire logic s_axi_wvalid, // Write data valid
    input wire logic s_axi_bvalid, // Write response valid
    input wire logic s_axi_bready, // Write response ready
    input wire logic s_axi_arvalid, // Read address valid
    input wire logic s_axi_arready, // Read address ready
    input wire logic s_axi_rvalid, // Read data valid
    input wire logic s_axi_rready, // Read data ready
    input wire pwehc_upd_t flag_update, // Hardware update
    input wire logic cfg_load_valid, // Config load pulse
    input wire logic cfg_enh_value, // Config bit value
    input wire logic [31:0] host_flags, // Flags
    input wire logic irq // Interrupt
);
    // ==========================================================
    // Properties
    default clocking cb @(posedge aclk); endclocking
    default disable iff (!aresetn);
    a_flags_reset: assert property (disable iff (1'b0) !aresetn |=> host_flags == PWEHC_FLAG_RESET)
        else $error("flags wrong after reset");
    a_irq_reset: assert property (disable iff (1'b0) !aresetn |=> !irq && !s_axi_awready)
        else $error("irq or ready up in reset");
    a_cfg_load: assert property (cfg_load_valid |=> host_flags[23] == $past(cfg_enh_value))
        else $error("config load missed");
    a_hw_update: assert property (flag_update.valid |=>
        host_flags[31] == $past(flag_update.value[31]) && host_flags[16] == $past(flag_update.value[16]))
        else $error("hardware update missed");
    a_ro_bits: assert property ((host_flags & ~(PWEHC_FLAG_SET_MASK | PWEHC_FLAG_RESET)) == 32'h0)
        else $error("read-only flag bit set");
    a_flags_quiet: assert property ((!s_axi_awvalid && !s_axi_wvalid && !flag_update.valid
        && !cfg_load_valid) [*2] |=> $stable(host_flags))
        else $error("flags changed without cause");
    a_read_answer: assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
        else $error("read answer late");
    a_read_done: assert property (s_axi_rvalid && s_axi_rready |=> !s_axi_rvalid)
        else $error("rvalid stuck");
    a_write_done: assert property (s_axi_bvalid && s_axi_bready |=> !s_axi_bvalid)
        else $error("bvalid stuck");
endmodule
bind pwehc_regs pwehc_regs_props pwehc_regs_props_inst (.aclk, .aresetn, .s_axi_awvalid, .s_axi_awready,
    .s_axi_wvalid, .s_axi_bvalid, .s_axi_bready, .s_axi_arvalid, .s_axi_arready, .s_axi_rvalid,
    .s_axi_rready, .flag_update, .cfg_load_valid, .cfg_enh_value, .host_flags, .irq);
`default_nettype wire

// File: test/tb.sv
// Testbench: register access sequences for the posted-write error and host control bank
`timescale 1ns/1ps
`default_nettype none
module tb;
    import pwehc_pkg::*;
    logic aclk = 0, aresetn = 0, awv = 0, wv = 0, bre = 0, arv = 0, rre = 0, fv = 0, cfv = 0, cfe = 0;
    logic awr, wr, bv, arr, rv, irq;
    logic [7:0] awa = 8'h0, ara = 8'h0;
    logic [31:0] wd = 32'h0, rd_d, rdw, flags;
    logic [1:0] br, rr, rd_r, wr_r;
    logic [3:0] ws = 4'hf;
    pwehc_fail_t fi = '0, f1, f2;
    pwehc_upd_t fu = '0;
    int err_total = 0, n_tests = 0;
    always #25 aclk = ~aclk;
    pwehc_regs pwehc_regs_inst (.aclk(aclk), .aresetn(aresetn), .s_axi_awaddr(awa), .s_axi_awvalid(awv),
        .s_axi_awready(awr), .s_axi_wdata(wd), .s_axi_wstrb(ws), .s_axi_wvalid(wv), .s_axi_wready(wr),
        .s_axi_bresp(br), .s_axi_bvalid(bv), .s_axi_bready(bre), .s_axi_araddr(ara), .s_axi_arvalid(arv),
        .s_axi_arready(arr), .s_axi_rdata(rdw), .s_axi_rresp(rr), .s_axi_rvalid(rv), .s_axi_rready(rre),
        .fail_valid(fv), .fail_info(fi), .flag_update(fu), .cfg_load_valid(cfv), .cfg_enh_value(cfe),
        .host_flags(flags), .irq(irq));
    // ==========================================================
    // Bus tasks and checks
    task automatic tick(input int k);
        repeat (k) @(posedge aclk);
    endtask
    task automatic chk(input logic [31:0] s, input logic [31:0] e);
        n_tests++;
        if (s !== e) begin
            err_total++;
            $display("BAD %0t seen %h expected %h", $time, s, e);
        end
    endtask
    task automatic axw(input logic [7:0] a, input logic [31:0] d);
        awa <= a;
        wd <= d;
        awv <= 1'b1;
        wv <= 1'b1;
        bre <= 1'b1;
        do begin
            @(posedge aclk);
            if (awr) awv <= 1'b0;
            if (wr) wv <= 1'b0;
        end while (!bv);
        wr_r = br;
        bre <= 1'b0;
        // One idle edge so the next call never re-raises bready in this step
        @(posedge aclk);
    endtask
    task automatic axr(input logic [7:0] a);
        ara <= a;
        arv <= 1'b1;
        rre <= 1'b1;
        do begin
            @(posedge aclk);
            if (arr) arv <= 1'b0;
        end while (!rv);
        rd_r = rr;
        rd_d = rdw;
        rre <= 1'b0;
        @(posedge aclk);
    endtask
    task automatic fail(input pwehc_fail_t f);
        fi <= f;
        fv <= 1'b1;
        tick(1);
        fv <= 1'b0;
        tick(2);
    endtask
    task automatic print_verdict();
        $display("Counts: %0d compares, %0d errors", n_tests, err_total);
        if (err_total == 0 && n_tests > 0) begin
            $display("bench passed");
        end else begin
            $display("bench failed");
        end
        $finish;
    endtask
    // ==========================================================
    // Sequence
    initial begin
        f1 = '{48'h1234_89ab_cdef, 10'h2c5, 6'h1a};
        f2 = '{48'hfedc_0000_0001, 10'h001, 6'h3f};
        tick(5);
        aresetn <= 1'b1;
        tick(1);
        axr(8'h50);
        chk(rd_d, PWEHC_FLAG_RESET);
        axw(8'h40, 32'hffff_ffff);
        chk({30'h0, wr_r}, {30'h0, PWEHC_RESP_OKAY});
        axr(8'h40);
        chk(rd_d, PWEHC_ORG_ID_VALUE);
        axw(8'h50, 32'hffff_ffff);
        axr(8'h54);
        chk(rd_d, 32'he0cf_0000);
        axw(8'h54, 32'hffff_ffff);
        axr(8'h50);
        chk(rd_d, 32'h8080_0000);
        axw(8'h54, 32'h0);
        axr(8'h54);
        chk(rd_d, 32'h8080_0000);
        // Top byte lane only: bits 31..29 set, lower settable bits untouched
        ws <= 4'h8;
        axw(8'h50, 32'hffff_ffff);
        ws <= 4'hf;
        axr(8'h50);
        chk(rd_d, 32'he080_0000);
        axw(8'h54, 32'hffff_ffff);
        fu <= '{1'b1, 32'h0001_0000};
        tick(1);
        fu <= '0;
        tick(1);
        chk(flags, 32'h0081_0000);
        cfv <= 1'b1;
        tick(1);
        cfv <= 1'b0;
        tick(1);
        chk(flags, 32'h0001_0000);
        fail(f1);
        chk({31'h0, irq}, 32'h0);
        axr(8'h60);
        chk(rd_d, 32'h1);
        axw(8'h64, 32'h1);
        axw(8'h68, 32'h1);
        fail(f2);
        chk({31'h0, irq}, 32'h1);
        axr(8'h38);
        chk(rd_d, f2.dest_offset[31:0]);
        axr(8'h3c);
        chk(rd_d, {f2.bus_num, f2.node_num, f2.dest_offset[47:32]});
        fail(f1);
        axw(8'h3c, 32'h0);
        axr(8'h3c);
        chk(rd_d, {f1.bus_num, f1.node_num, f1.dest_offset[47:32]});
        axw(8'h38, 32'h0);
        axr(8'h38);
        chk(rd_d, f1.dest_offset[31:0]);
        axw(8'h64, 32'h1);
        tick(2);
        chk({31'h0, irq}, 32'h0);
        axw(8'h7c, 32'h0);
        chk({30'h0, wr_r}, {30'h0, PWEHC_RESP_SLVERR});
        axr(8'h7c);
        chk({rd_d[29:0], rd_r}, {30'h0, PWEHC_RESP_SLVERR});
        print_verdict();
    end
    initial begin
        tick(3000);
        err_total++;
        print_verdict();
    end
endmodule
`default_nettype wire
